// [hdl/reload_capture_timer.sv]
// Sixteen-bit reload/capture timer with split mode, on the special function register port
// Functional notes
// - 16-bit mode: on FFFF rollover load reload value and set high flag.
// - 16-bit mode interrupts on full overflow, plus low-byte rollovers if enabled.
// - Split mode runs two 8-bit auto-reload timers from their own reload bytes.
// - Run bit gates whole timer in 16-bit mode, only high byte in split.
// - Split bytes tick on system clock if own fast select, else the alternative clock; 16-bit mode follows the low select.
// - One external-clock select bit picks the alternative clock for both bytes.
// - External clock is synchronised, then divided by eight, before advancing the counter.
// - Split mode: high byte rollover sets high flag, low rollover low flag.
// - Split mode interrupts on high overflow, or either byte when low enable set.
// - Overflow flags are cleared only by software writes; software checks both.
// - Low flag sets on every low-byte rollover in every mode.
// - Capture source select: 0 start-of-frame, 1 low-frequency oscillator rising edge.
// - Capture 16-bit: count wraps; event copies count to reload, requests interrupt.
// - Capture split: bytes wrap independently; event copies both bytes, requests interrupt.
// - Control register bit map and all-zero reset value.
// - Reload bytes are read/write, reset zero, hold reload or captured value.
// - Count bytes are read/write, reset zero, form the 16-bit or split counts.
`timescale 1ns/1ps
`default_nettype none
module reload_capture_timer
   import timer_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr_en,
   input  wire logic       sfr_rd_en,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       high_fast_clock_sel,
   input  wire logic       low_fast_clock_sel,
   input  wire logic       ext_osc_clk,
   input  wire logic       sof_pulse,
   input  wire logic       low_freq_osc,
   input  wire logic       timer_irq_en,
   output logic            irq_req
);
   logic [7:0] control_q;
   logic [7:0] reload_lo_q;
   logic [7:0] reload_hi_q;
   logic [7:0] count_lo_q;
   logic [7:0] count_hi_q;
   logic [7:0] count_lo_d;
   logic [7:0] count_hi_d;
   logic [7:0] rdata_q;
   logic       irq_q;
   logic [2:0] sof_sync_q;
   logic [2:0] lfo_sync_q;
   logic       set_high_ovf;
   logic       set_low_ovf;
   logic       capture_evt;
   logic       adv_lo;
   logic       adv_hi;
   logic       wr_ctrl;
   logic       high_ovf;
   logic       low_ovf;
   logic       low_irq_en;
   logic       capture_en;
   logic       split;
   logic       run;

   tick_if tk ();

   assign tk.fast_high = high_fast_clock_sel;
   assign tk.fast_low  = low_fast_clock_sel;
   assign tk.ext_sel   = control_q[BIT_EXT_CLK];

   count_tick_gen u_tick (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .ext_osc_clk (ext_osc_clk),
      .tk          (tk)
   );

   assign high_ovf   = control_q[BIT_HIGH_OVF];
   assign low_ovf    = control_q[BIT_LOW_OVF];
   assign low_irq_en = control_q[BIT_LOW_IRQ_EN];
   assign capture_en = control_q[BIT_CAPTURE_EN];
   assign split      = control_q[BIT_SPLIT];
   assign run        = control_q[BIT_RUN];
   assign wr_ctrl    = sfr_wr_en && (sfr_addr == ADDR_CONTROL);

   // Bit 0 of each chain is read only by bit 1; edges use bits 1 and 2
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sof_sync_q <= 3'h0;
         lfo_sync_q <= 3'h0;
      end else begin
         sof_sync_q <= {sof_sync_q[1:0], sof_pulse};
         lfo_sync_q <= {lfo_sync_q[1:0], low_freq_osc};
      end
   end

   always_comb begin
      capture_evt = 1'b0;
      if (capture_en) begin
         if (control_q[BIT_CAPTURE_SRC]) begin
            capture_evt = lfo_sync_q[1] & ~lfo_sync_q[2];
         end else begin
            capture_evt = sof_sync_q[1] & ~sof_sync_q[2];
         end
      end
   end

   // Low byte runs free in split mode; 16-bit mode uses the low byte's tick
   assign adv_lo = tk.tick_low & (split | run);
   assign adv_hi = tk.tick_high & run;

   always_comb begin
      count_lo_d   = count_lo_q;
      count_hi_d   = count_hi_q;
      set_low_ovf  = 1'b0;
      set_high_ovf = capture_evt;
      if (!split) begin
         if (adv_lo) begin
            set_low_ovf = (count_lo_q == BYTE_MAX);
            if ({count_hi_q, count_lo_q} == WORD_MAX) begin
               set_high_ovf = 1'b1;
               if (capture_en) begin
                  {count_hi_d, count_lo_d} = 16'h0000;
               end else begin
                  {count_hi_d, count_lo_d} = {reload_hi_q, reload_lo_q};
               end
            end else begin
               {count_hi_d, count_lo_d} = 16'({count_hi_q, count_lo_q} + 16'h0001);
            end
         end
      end else begin
         if (adv_lo) begin
            if (count_lo_q == BYTE_MAX) begin
               set_low_ovf = 1'b1;
               count_lo_d  = capture_en ? 8'h00 : reload_lo_q;
            end else begin
               count_lo_d = 8'(count_lo_q + 8'h01);
            end
         end
         if (adv_hi) begin
            if (count_hi_q == BYTE_MAX) begin
               set_high_ovf = 1'b1;
               count_hi_d   = capture_en ? 8'h00 : reload_hi_q;
            end else begin
               count_hi_d = 8'(count_hi_q + 8'h01);
            end
         end
      end
   end

   // A software write to a count byte wins over the tick in that cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_lo_q <= BYTE_RESET;
         count_hi_q <= BYTE_RESET;
      end else begin
         count_lo_q <= (sfr_wr_en && sfr_addr == ADDR_COUNT_LO) ? sfr_wdata : count_lo_d;
         count_hi_q <= (sfr_wr_en && sfr_addr == ADDR_COUNT_HI) ? sfr_wdata : count_hi_d;
      end
   end

   // Capture wins over a software write so no measured edge is lost
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reload_lo_q <= BYTE_RESET;
         reload_hi_q <= BYTE_RESET;
      end else if (capture_evt) begin
         reload_lo_q <= count_lo_q;
         reload_hi_q <= count_hi_q;
      end else if (sfr_wr_en) begin
         if (sfr_addr == ADDR_RELOAD_LO) begin
            reload_lo_q <= sfr_wdata;
         end
         if (sfr_addr == ADDR_RELOAD_HI) begin
            reload_hi_q <= sfr_wdata;
         end
      end
   end

   // Flags: hardware set beats a software clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         control_q <= CONTROL_RESET;
      end else begin
         if (wr_ctrl) begin
            control_q[5:0] <= sfr_wdata[5:0];
         end
         control_q[BIT_HIGH_OVF] <= (wr_ctrl ? sfr_wdata[BIT_HIGH_OVF] : high_ovf)
                                    | set_high_ovf;
         control_q[BIT_LOW_OVF]  <= (wr_ctrl ? sfr_wdata[BIT_LOW_OVF] : low_ovf)
                                    | set_low_ovf;
      end
   end

   // Request stays up while an enabled flag is set; the core never clears flags itself
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= timer_irq_en & (high_ovf | (low_irq_en & low_ovf));
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (sfr_rd_en) begin
         case (sfr_addr)
            ADDR_CONTROL:   rdata_q <= control_q;
            ADDR_RELOAD_LO: rdata_q <= reload_lo_q;
            ADDR_RELOAD_HI: rdata_q <= reload_hi_q;
            ADDR_COUNT_LO:  rdata_q <= count_lo_q;
            ADDR_COUNT_HI:  rdata_q <= count_hi_q;
            default:        rdata_q <= 8'h00;
         endcase
      end
   end

   assign sfr_rdata = rdata_q;
   assign irq_req   = irq_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Only a write to a count byte can override the wrap; other writes leave it alone
   sequence s_full_wrap;
      !(sfr_wr_en && (sfr_addr == ADDR_COUNT_LO || sfr_addr == ADDR_COUNT_HI))
         && !split && adv_lo && ({count_hi_q, count_lo_q} == WORD_MAX);
   endsequence

   sequence s_flag_cause;
      high_ovf || (low_irq_en && low_ovf);
   endsequence

   chk_full_reload_load: assert property (
      (s_full_wrap ##0 !capture_en) |=>
         ({count_hi_q, count_lo_q} == {$past(reload_hi_q), $past(reload_lo_q)}) && high_ovf)
      else $error("16-bit overflow did not reload or flag");
   chk_capture_wrap_zero: assert property (
      (s_full_wrap ##0 capture_en) |=> ({count_hi_q, count_lo_q} == 16'h0000) && high_ovf)
      else $error("capture count did not wrap to zero");
   chk_low_flag_any: assert property (
      (adv_lo && count_lo_q == BYTE_MAX) |=> low_ovf)
      else $error("low rollover did not set low flag");
   chk_split_low_free: assert property (
      (!sfr_wr_en && split && !run && tk.tick_low && count_lo_q != BYTE_MAX)
      |=> count_lo_q == 8'($past(count_lo_q) + 8'h01))
      else $error("split low byte did not run with run bit clear");
   chk_split_high_hold: assert property (
      (!sfr_wr_en && split && !run) |=> $stable(count_hi_q))
      else $error("split high byte moved with run bit clear");
   chk_split_high_reload: assert property (
      (!sfr_wr_en && split && !capture_en && adv_hi && count_hi_q == BYTE_MAX)
      |=> count_hi_q == $past(reload_hi_q) && high_ovf)
      else $error("split high byte did not reload");
   chk_flag_sticky_hold: assert property (
      (high_ovf && !wr_ctrl) |=> high_ovf)
      else $error("high flag cleared without a write");
   chk_capture_copy_count: assert property (
      capture_evt |=> reload_lo_q == $past(count_lo_q) && reload_hi_q == $past(count_hi_q))
      else $error("capture did not copy the count");
   chk_irq_from_flags: assert property (
      (s_flag_cause ##0 timer_irq_en) |=> irq_req)
      else $error("interrupt not requested for a set flag");
   chk_irq_only_cause: assert property (
      irq_req |-> $past(timer_irq_en) && ($past(high_ovf) || ($past(low_irq_en) && $past(low_ovf))))
      else $error("interrupt requested without cause");
endmodule : reload_capture_timer
`default_nettype wire

// [hdl/timer_pkg.sv]
// Constants shared by the reload/capture timer and its tick generator
package timer_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] ADDR_CONTROL   = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LO = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HI = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LO  = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HI  = 8'h95;

   // Control register bit positions
   localparam int BIT_HIGH_OVF    = 7;
   localparam int BIT_LOW_OVF     = 6;
   localparam int BIT_LOW_IRQ_EN  = 5;
   localparam int BIT_CAPTURE_EN  = 4;
   localparam int BIT_SPLIT       = 3;
   localparam int BIT_RUN         = 2;
   localparam int BIT_CAPTURE_SRC = 1;
   localparam int BIT_EXT_CLK     = 0;

   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET    = 8'h00;

   // Byte and word limits
   localparam logic [7:0]  BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;

   // Tick dividers in clock cycles
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
   localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
   localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);
endpackage : timer_pkg

// [hdl/tick_if.sv]
// Tick selects and tick strobes between the timer core and its tick generator
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic fast_high;
   logic fast_low;
   logic ext_sel;
   logic tick_high;
   logic tick_low;
   modport gen (input fast_high, input fast_low, input ext_sel,
                output tick_high, output tick_low);
   modport use_ticks (output fast_high, output fast_low, output ext_sel,
                      input tick_high, input tick_low);
endinterface : tick_if
`default_nettype wire

// [hdl/count_tick_gen.sv]
// Per-byte count tick generator: system clock, divided by 12, or external clock by 8
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen
   import timer_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic ext_osc_clk,
   tick_if.gen       tk
);
   logic       ext_s1_q;
   logic       ext_s2_q;
   logic       ext_s3_q;
   logic [2:0] ext_div_q;
   logic [3:0] sys_div_q;
   logic       ext_rise;
   logic       ext_tick;
   logic       sys_tick;
   logic       alt_tick;

   // External oscillator brought into the system clock before use
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_osc_clk;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_rise = ext_s2_q & ~ext_s3_q;
   assign ext_tick = ext_rise && (ext_div_q == EXT_DIV_LAST);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_div_q <= 3'h0;
      end else if (ext_rise) begin
         ext_div_q <= 3'(ext_div_q + 3'h1);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sys_div_q <= 4'h0;
      end else if (sys_div_q == SYS_DIV_LAST) begin
         sys_div_q <= 4'h0;
      end else begin
         sys_div_q <= 4'(sys_div_q + 4'h1);
      end
   end

   assign sys_tick = (sys_div_q == SYS_DIV_LAST);
   // One alternative source serves both bytes; each byte may override it
   assign alt_tick     = tk.ext_sel ? ext_tick : sys_tick;
   assign tk.tick_low  = tk.fast_low | alt_tick;
   assign tk.tick_high = tk.fast_high | alt_tick;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_fast_tick_every: assert property (tk.fast_low |-> tk.tick_low)
      else $error("fast low select did not tick every cycle");
   chk_sys_div_period: assert property (
      (!tk.fast_low && !tk.ext_sel && tk.tick_low) ##1 (!tk.fast_low && !tk.ext_sel) [*8]
      |-> !tk.tick_low)
      else $error("divided system tick came early");
endmodule : count_tick_gen
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the reload/capture timer through its register port
`timescale 1ns/1ps
`default_nettype none
module tb
   import timer_pkg::*;
;
   logic       ref_clk;
   logic       rst;
   logic [7:0] sfr_addr;
   logic       sfr_wr_en;
   logic       sfr_rd_en;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic       high_fast_clock_sel;
   logic       low_fast_clock_sel;
   logic       ext_osc_clk;
   logic       sof_pulse;
   logic       low_freq_osc;
   logic       timer_irq_en;
   logic       irq_req;
   int         fail_count;
   int         checks;
   logic [7:0] rv;

   reload_capture_timer dut (
      .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
      .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .high_fast_clock_sel(high_fast_clock_sel), .low_fast_clock_sel(low_fast_clock_sel),
      .ext_osc_clk(ext_osc_clk), .sof_pulse(sof_pulse), .low_freq_osc(low_freq_osc),
      .timer_irq_en(timer_irq_en), .irq_req(irq_req));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Free-running oscillator, unrelated in phase, well under half the system clock
   initial begin
      ext_osc_clk = 1'b0;
      #3;
      forever #20 ext_osc_clk = ~ext_osc_clk;
   end

   task automatic test_done;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
      check({15'h0000, (v >= lo) && (v <= hi)}, 16'h0001);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr_en = 1'b1;
      @(posedge ref_clk);
      #1;
      sfr_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      sfr_addr  = a;
      sfr_rd_en = 1'b1;
      @(posedge ref_clk);
      #1;
      sfr_rd_en = 1'b0;
      @(posedge ref_clk);
      #1;
      d = sfr_rdata;
   endtask

   task automatic load_count(input logic [7:0] hi, input logic [7:0] lo);
      wr(ADDR_COUNT_HI, hi);
      wr(ADDR_COUNT_LO, lo);
   endtask

   task automatic test_reset_values;
      rd(ADDR_CONTROL, rv);   check(16'(rv), 16'(CONTROL_RESET));
      rd(ADDR_RELOAD_LO, rv); check(16'(rv), 16'(BYTE_RESET));
      rd(ADDR_RELOAD_HI, rv); check(16'(rv), 16'(BYTE_RESET));
      rd(ADDR_COUNT_LO, rv);  check(16'(rv), 16'(BYTE_RESET));
      rd(ADDR_COUNT_HI, rv);  check(16'(rv), 16'(BYTE_RESET));
      rd(8'h90, rv);          check(16'(rv), 16'h0000);
      check(16'(irq_req), 16'h0000);
   endtask

   task automatic test_word_reload;
      logic [7:0] prev;
      low_fast_clock_sel = 1'b1;
      timer_irq_en = 1'b1;
      wr(ADDR_RELOAD_LO, 8'h34);
      wr(ADDR_RELOAD_HI, 8'h12);
      load_count(8'hFF, 8'hFE);
      wr(ADDR_CONTROL, 8'h04);
      wait_cyc(10);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h00C4);
      check(16'(irq_req), 16'h0001);
      wait_cyc(6);
      check(16'(irq_req), 16'h0001);
      wr(ADDR_CONTROL, 8'h00);
      wait_cyc(2);
      #1;
      check(16'(irq_req), 16'h0000);
      rd(ADDR_COUNT_HI, rv); check(16'(rv), 16'h0012);
      rd(ADDR_COUNT_LO, rv); in_range(rv, 8'h34, 8'h50);
      prev = rv;
      // Run bit clear in 16-bit mode: both bytes stay where they stopped
      wait_cyc(20);
      rd(ADDR_COUNT_HI, rv); check(16'(rv), 16'h0012);
      rd(ADDR_COUNT_LO, rv); check(16'(rv), 16'(prev));
   endtask

   task automatic test_split;
      high_fast_clock_sel = 1'b1;
      wr(ADDR_RELOAD_LO, 8'h80);
      wr(ADDR_RELOAD_HI, 8'h40);
      load_count(8'hFE, 8'hFD);
      // Split with the run bit off: only the low byte may move
      wr(ADDR_CONTROL, 8'h28);
      wait_cyc(20);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h0068);
      check(16'(irq_req), 16'h0001);
      rd(ADDR_COUNT_HI, rv); check(16'(rv), 16'h00FE);
      rd(ADDR_COUNT_LO, rv); in_range(rv, 8'h80, 8'hA0);
      wr(ADDR_CONTROL, 8'h0C);
      wait_cyc(10);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h008C);
      check(16'(irq_req), 16'h0001);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_HI, rv); in_range(rv, 8'h40, 8'h50);
   endtask

   task automatic test_tick_sources;
      high_fast_clock_sel = 1'b0;
      low_fast_clock_sel = 1'b0;
      load_count(8'h00, 8'h00);
      wr(ADDR_CONTROL, 8'h04);
      wait_cyc(120);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LO, rv); in_range(rv, 8'd9, 8'd11);
      load_count(8'h00, 8'h00);
      wr(ADDR_CONTROL, 8'h05);
      wait_cyc(400);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LO, rv); in_range(rv, 8'd9, 8'd11);
      // Split: high byte overrides to the system clock, low keeps ext/8
      high_fast_clock_sel = 1'b1;
      load_count(8'h00, 8'h00);
      wr(ADDR_CONTROL, 8'h0D);
      wait_cyc(40);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LO, rv); in_range(rv, 8'd0, 8'd2);
      rd(ADDR_COUNT_HI, rv); in_range(rv, 8'd38, 8'd46);
   endtask

   task automatic test_capture;
      low_fast_clock_sel = 1'b1;
      // Run bit off keeps the count frozen, so the captured value is exact
      wr(ADDR_CONTROL, 8'h10);
      load_count(8'hA5, 8'h5A);
      sof_pulse = 1'b1;
      wait_cyc(4);
      sof_pulse = 1'b0;
      wait_cyc(6);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h0090);
      check(16'(irq_req), 16'h0001);
      rd(ADDR_RELOAD_HI, rv); check(16'(rv), 16'h00A5);
      rd(ADDR_RELOAD_LO, rv); check(16'(rv), 16'h005A);
      wr(ADDR_CONTROL, 8'h12);
      load_count(8'h11, 8'h22);
      sof_pulse = 1'b1;
      wait_cyc(4);
      sof_pulse = 1'b0;
      wait_cyc(6);
      rd(ADDR_RELOAD_LO, rv); check(16'(rv), 16'h005A);
      low_freq_osc = 1'b1;
      wait_cyc(6);
      rd(ADDR_RELOAD_HI, rv); check(16'(rv), 16'h0011);
      rd(ADDR_RELOAD_LO, rv); check(16'(rv), 16'h0022);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h0092);
      // A second capture must not follow from the same level
      wr(ADDR_CONTROL, 8'h12);
      load_count(8'h33, 8'h44);
      low_freq_osc = 1'b0;
      wait_cyc(6);
      rd(ADDR_RELOAD_HI, rv); check(16'(rv), 16'h0011);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h0012);
      // Capture modes wrap to zero instead of reloading; the wrap lands with the clear
      load_count(8'hFF, 8'hFE);
      wr(ADDR_CONTROL, 8'h16);
      wr(ADDR_CONTROL, 8'h12);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h00D2);
      rd(ADDR_COUNT_HI, rv); check(16'(rv), 16'h0000);
      rd(ADDR_COUNT_LO, rv); check(16'(rv), 16'h0000);
      load_count(8'hFE, 8'hFE);
      wr(ADDR_CONTROL, 8'h1E);
      wr(ADDR_CONTROL, 8'h12);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h00D2);
      rd(ADDR_COUNT_HI, rv); check(16'(rv), 16'h0000);
      rd(ADDR_COUNT_LO, rv); check(16'(rv), 16'h0000);
      // Split capture with run clear: high byte frozen, low byte free
      wr(ADDR_CONTROL, 8'h1A);
      low_freq_osc = 1'b1;
      wait_cyc(6);
      rd(ADDR_RELOAD_HI, rv); check(16'(rv), 16'h0000);
      rd(ADDR_RELOAD_LO, rv); in_range(rv, 8'h01, 8'h03);
      rd(ADDR_CONTROL, rv); check(16'(rv), 16'h009A);
   endtask

   initial begin
      rst = 1'b1;
      sfr_addr = 8'h00;
      sfr_wr_en = 1'b0;
      sfr_rd_en = 1'b0;
      sfr_wdata = 8'h00;
      high_fast_clock_sel = 1'b0;
      low_fast_clock_sel = 1'b0;
      sof_pulse = 1'b0;
      low_freq_osc = 1'b0;
      timer_irq_en = 1'b0;
      fail_count = 0;
      checks = 0;
      wait_cyc(20);
      #1;
      rst = 1'b0;
      test_reset_values();
      test_word_reload();
      test_split();
      test_tick_sources();
      test_capture();
      test_done();
   end

   // The sequence needs about 900 cycles; over twenty times that means a hang
   initial begin
      wait_cyc(20000);
      fail_count++;
      test_done();
   end
endmodule // tb
`default_nettype wire
